/* File: hw/irq_prio_pkg.sv */
// Package for the extended interrupt priority and enable registers.
// Assumes an 8-bit special-function-register bus on one clock.
package irq_prio_pkg;
   localparam int NUM_SRC = 6;
   localparam int ID_W = 3;

   // Register addresses
   localparam logic [7:0] ADDR_PRIO_ONE = 8'hF6;
   localparam logic [7:0] ADDR_ENABLE_TWO = 8'hE7;
   localparam logic [7:0] ADDR_PRIO_TWO = 8'hF7;

   // Reset values
   localparam logic [7:0] RST_PRIO_ONE = 8'h00;
   localparam logic [7:0] RST_ENABLE_TWO = 8'h00;
   localparam logic [7:0] RST_PRIO_TWO = 8'h00;

   // Field positions in the first priority register
   localparam int POS_COUNTER_ARRAY_PRIO = 4;
   localparam int POS_ADC_DONE_PRIO = 3;
   localparam int POS_ADC_WINDOW_PRIO = 2;
   localparam int POS_USB_PRIO = 1;
   localparam int POS_SMBUS_PRIO = 0;
   // Field positions in the second enable and priority registers
   localparam int POS_VBUS_ENABLE = 0;
   localparam int POS_VBUS_PRIO = 0;

   // Source index; lower index is polled first
   localparam logic [2:0] SRC_SMBUS = 3'h0;
   localparam logic [2:0] SRC_USB = 3'h1;
   localparam logic [2:0] SRC_ADC_WINDOW = 3'h2;
   localparam logic [2:0] SRC_ADC_DONE = 3'h3;
   localparam logic [2:0] SRC_COUNTER_ARRAY = 3'h4;
   localparam logic [2:0] SRC_VBUS = 3'h5;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_type;

   typedef struct packed {
      logic valid;
      logic high;
      logic [2:0] id;
      logic preempt;
   } irq_sel_type;
endpackage : irq_prio_pkg

/* File: hw/interrupt_priority_enable_regs.sv */
// Extended priority and enable registers plus the two-level source selector.
// Assumes the core drives the SFR bus on ref_clk_i; requests come from logic
// on the same clock; enables of the first five sources come from elsewhere.
`timescale 1ns/1ps

//Summary of operation
//- First priority register holds five source bits
//- Bit 4 sets counter-array low/high priority
//- Bit 3 sets ADC done low/high priority
//- Enable register 0xE7 bit0 masks VBUS
//- Priority register 0xF7 bit0 sets VBUS level
//- First priority register 0xF6, resets zero
module interrupt_priority_enable_regs
   import irq_prio_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // SFR bus
   input wire sfr_req_type sfr_i,
   output logic [7:0] sfr_rdata_o,
   // Source requests and external enables, index order of the package
   input wire logic [NUM_SRC-1:0] src_req_i,
   input wire logic [NUM_SRC-2:0] src_enable_i,
   // Core service state
   input wire logic in_service_low_i,
   input wire logic in_service_high_i,
   // Selection to the core
   output irq_sel_type irq_sel_o,
   output logic [NUM_SRC-1:0] src_prio_o
);

   logic [7:0] prio_one_ff;
   logic [7:0] enable_two_ff;
   logic [7:0] prio_two_ff;
   logic [7:0] rdata_ff;
   irq_sel_type sel_ff;
   irq_sel_type nxt_sel;
   logic [NUM_SRC-1:0] prio_vec;
   logic [NUM_SRC-1:0] en_vec;
   logic [NUM_SRC-1:0] pend_vec;
   logic [NUM_SRC-1:0] high_vec;

   function automatic logic [2:0] first_set(input logic [NUM_SRC-1:0] v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction : first_set

   // First priority register; bits 7..5 are kept for other sources
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         prio_one_ff <= RST_PRIO_ONE;
      end else if (sfr_i.wr && sfr_i.addr == ADDR_PRIO_ONE) begin
         prio_one_ff <= sfr_i.wdata;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         enable_two_ff <= RST_ENABLE_TWO;
      end else if (sfr_i.wr && sfr_i.addr == ADDR_ENABLE_TWO) begin
         enable_two_ff <= {7'h00, sfr_i.wdata[POS_VBUS_ENABLE]};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         prio_two_ff <= RST_PRIO_TWO;
      end else if (sfr_i.wr && sfr_i.addr == ADDR_PRIO_TWO) begin
         prio_two_ff <= {7'h00, sfr_i.wdata[POS_VBUS_PRIO]};
      end
   end

   // Read data; unmapped addresses read zero
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rdata_ff <= 8'h00;
      end else if (sfr_i.rd) begin
         case (sfr_i.addr)
            ADDR_PRIO_ONE: rdata_ff <= prio_one_ff;
            ADDR_ENABLE_TWO: rdata_ff <= enable_two_ff;
            ADDR_PRIO_TWO: rdata_ff <= prio_two_ff;
            default: rdata_ff <= 8'h00;
         endcase
      end
   end

   // Level per source, 0 low and 1 high
   always_comb begin
      prio_vec[SRC_SMBUS] = prio_one_ff[POS_SMBUS_PRIO];
      prio_vec[SRC_USB] = prio_one_ff[POS_USB_PRIO];
      prio_vec[SRC_ADC_WINDOW] = prio_one_ff[POS_ADC_WINDOW_PRIO];
      prio_vec[SRC_ADC_DONE] = prio_one_ff[POS_ADC_DONE_PRIO];
      prio_vec[SRC_COUNTER_ARRAY] = prio_one_ff[POS_COUNTER_ARRAY_PRIO];
      prio_vec[SRC_VBUS] = prio_two_ff[POS_VBUS_PRIO];
      en_vec = {enable_two_ff[POS_VBUS_ENABLE], src_enable_i};
      pend_vec = src_req_i & en_vec;
      high_vec = pend_vec & prio_vec;
   end

   // High level pending wins; within a level lowest index wins
   always_comb begin
      nxt_sel.valid = |pend_vec;
      nxt_sel.high = |high_vec;
      nxt_sel.id = (|high_vec) ? first_set(high_vec) : first_set(pend_vec);
      nxt_sel.preempt = (|high_vec) && in_service_low_i && !in_service_high_i;
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         sel_ff <= '0;
      end else begin
         sel_ff <= nxt_sel;
      end
   end

   assign sfr_rdata_o = rdata_ff;
   assign irq_sel_o = sel_ff;
   assign src_prio_o = prio_vec;

   // Checks
   property p_prio_one_write;
      @(posedge ref_clk_i) disable iff (srst_i)
      sfr_i.wr && sfr_i.addr == ADDR_PRIO_ONE |=> prio_one_ff == $past(sfr_i.wdata);
   endproperty
   a_prio_one_write: assert property (p_prio_one_write) else $error("prio one not written");

   property p_counter_array_level;
      @(posedge ref_clk_i) disable iff (srst_i)
      src_req_i == 6'h10 && src_enable_i[4] |=> sel_ff.high == $past(prio_one_ff[4]);
   endproperty
   a_counter_array_level: assert property (p_counter_array_level) else $error("pca level");

   property p_adc_done_level;
      @(posedge ref_clk_i) disable iff (srst_i)
      src_req_i == 6'h08 && src_enable_i[3] |=> sel_ff.high == $past(prio_one_ff[3]);
   endproperty
   a_adc_done_level: assert property (p_adc_done_level) else $error("adc done level");

   property p_usb_level;
      @(posedge ref_clk_i) disable iff (srst_i)
      src_req_i == 6'h02 && src_enable_i[1] |=> sel_ff.high == $past(prio_one_ff[1]);
   endproperty
   a_usb_level: assert property (p_usb_level) else $error("usb level");

   property p_vbus_masked;
      @(posedge ref_clk_i) disable iff (srst_i)
      src_req_i == 6'h20 && !enable_two_ff[0] |=> !sel_ff.valid;
   endproperty
   a_vbus_masked: assert property (p_vbus_masked) else $error("vbus not masked");

   property p_unused_zero;
      @(posedge ref_clk_i) disable iff (srst_i)
      sfr_i.rd && (sfr_i.addr == ADDR_PRIO_TWO || sfr_i.addr == ADDR_ENABLE_TWO)
      |=> sfr_rdata_o[7:1] == 7'h00;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits nonzero");

   property p_reset_zero;
      @(posedge ref_clk_i) srst_i |=> prio_one_ff == 8'h00 && prio_two_ff == 8'h00;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

   property p_high_first;
      @(posedge ref_clk_i) disable iff (srst_i)
      |high_vec |=> sel_ff.high && prio_vec[sel_ff.id] || $past(sfr_i.wr);
   endproperty
   a_high_first: assert property (p_high_first) else $error("low served first");

   property p_preempt;
      @(posedge ref_clk_i) disable iff (srst_i)
      $rose(sel_ff.preempt) |-> $past(in_service_low_i) && sel_ff.high;
   endproperty
   a_preempt: assert property (p_preempt) else $error("bad preempt");

   property p_enable_two_write;
      @(posedge ref_clk_i) disable iff (srst_i)
      sfr_i.wr && sfr_i.addr == ADDR_ENABLE_TWO |=> enable_two_ff[7:1] == 7'h00
      && enable_two_ff[POS_VBUS_ENABLE] == $past(sfr_i.wdata[POS_VBUS_ENABLE]);
   endproperty
   a_enable_two_write: assert property (p_enable_two_write) else $error("vbus enable");

   property p_prio_two_write;
      @(posedge ref_clk_i) disable iff (srst_i)
      sfr_i.wr && sfr_i.addr == ADDR_PRIO_TWO |=> prio_two_ff[7:1] == 7'h00
      && prio_two_ff[POS_VBUS_PRIO] == $past(sfr_i.wdata[POS_VBUS_PRIO]);
   endproperty
   a_prio_two_write: assert property (p_prio_two_write) else $error("vbus prio");

   property p_reset_outputs;
      @(posedge ref_clk_i) srst_i |=> enable_two_ff == RST_ENABLE_TWO && sfr_rdata_o == 8'h00
      && !irq_sel_o.valid;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs) else $error("reset outputs");

   property p_smbus_first;
      @(posedge ref_clk_i) disable iff (srst_i)
      pend_vec[SRC_SMBUS] && !(|high_vec)
      |=> sel_ff.valid && !sel_ff.high && sel_ff.id == SRC_SMBUS;
   endproperty
   a_smbus_first: assert property (p_smbus_first) else $error("polling order");

   property p_high_preempts;
      @(posedge ref_clk_i) disable iff (srst_i)
      (|high_vec) && in_service_low_i && !in_service_high_i |=> sel_ff.preempt;
   endproperty
   a_high_preempts: assert property (p_high_preempts) else $error("no preempt");

   property p_no_preempt_in_high;
      @(posedge ref_clk_i) disable iff (srst_i)
      in_service_high_i |=> !sel_ff.preempt;
   endproperty
   a_no_preempt_in_high: assert property (p_no_preempt_in_high) else $error("preempt of high");

   c_vbus_high: cover property (@(posedge ref_clk_i) sel_ff.valid && sel_ff.id == SRC_VBUS
      && sel_ff.high);
   c_preempt: cover property (@(posedge ref_clk_i) sel_ff.preempt);
   c_two_low: cover property (@(posedge ref_clk_i) !sel_ff.high && $countones(pend_vec) > 1);
   c_usb_high: cover property (@(posedge ref_clk_i) sel_ff.valid && sel_ff.id == SRC_USB
      && sel_ff.high);
endmodule : interrupt_priority_enable_regs

/* File: verification/irq_src_model.sv */
// Peripheral request sources and core service state.
// Assumes the bench sets wanted levels; they reach the design one clock later.
`timescale 1ns/1ps
module irq_src_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // Wanted levels
   input wire logic [5:0] req_set_i,
   input wire logic [4:0] en_set_i,
   input wire logic [1:0] svc_set_i,
   // Levels to the design
   output logic [5:0] src_req_o,
   output logic [4:0] src_enable_o,
   output logic [1:0] svc_o
);
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         src_req_o <= 6'h00;
         src_enable_o <= 5'h00;
         svc_o <= 2'h0;
      end else begin
         src_req_o <= req_set_i;
         src_enable_o <= en_set_i;
         svc_o <= svc_set_i;
      end
   end
endmodule : irq_src_model

/* File: verification/interrupt_priority_enable_regs_bench.sv */
// Self-checking bench for the extended priority and enable registers.
// Assumes the package constants and the source model beside it.
`timescale 1ns/1ps
module interrupt_priority_enable_regs_bench;
   import irq_prio_pkg::*;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   sfr_req_type sfr = '0;
   logic [7:0] rdata;
   logic [5:0] req = '0;
   logic [4:0] en = '0;
   logic [1:0] svc = '0;
   logic [5:0] src_req;
   logic [4:0] src_en;
   logic [1:0] svc_m;
   irq_sel_type sel;
   logic [5:0] prio;
   int miscompares = 0;
   int total_checks = 0;
   initial forever #10 ref_clk_i = ~ref_clk_i;
   irq_src_model model_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .req_set_i(req),
      .en_set_i(en), .svc_set_i(svc), .src_req_o(src_req), .src_enable_o(src_en),
      .svc_o(svc_m));
   interrupt_priority_enable_regs dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .sfr_i(sfr), .sfr_rdata_o(rdata), .src_req_i(src_req), .src_enable_i(src_en),
      .in_service_low_i(svc_m[0]), .in_service_high_i(svc_m[1]), .irq_sel_o(sel),
      .src_prio_o(prio));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      sfr <= '{1'b1, 1'b0, a, d};
      @(posedge ref_clk_i);
      sfr <= '0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk_i);
      sfr <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge ref_clk_i);
      sfr <= '0;
      #1;
      chk(rdata, exp);
   endtask : rd
   task automatic drive(input logic [5:0] r, input logic [4:0] e, input logic [1:0] s);
      @(posedge ref_clk_i);
      req <= r;
      en <= e;
      svc <= s;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask : drive
   task automatic test_done;
      if (miscompares == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   initial begin
      repeat (10) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      rd(ADDR_PRIO_ONE, RST_PRIO_ONE);
      rd(ADDR_ENABLE_TWO, RST_ENABLE_TWO);
      rd(ADDR_PRIO_TWO, RST_PRIO_TWO);
      wr(ADDR_PRIO_ONE, 8'hFF);
      rd(ADDR_PRIO_ONE, 8'hFF);
      wr(ADDR_ENABLE_TWO, 8'hFF);
      rd(ADDR_ENABLE_TWO, 8'h01);
      wr(ADDR_PRIO_TWO, 8'hFF);
      rd(ADDR_PRIO_TWO, 8'h01);
      chk({2'b00, prio}, 8'h3F);
      rd(8'hE8, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_PRIO_ONE, 8'h01 << i);
         chk({2'b00, prio}, 8'h20 | (8'h01 << i));
      end
      wr(ADDR_PRIO_ONE, 8'h10);
      wr(ADDR_PRIO_TWO, 8'h00);
      drive(6'h11, 5'h11, 2'b00);
      chk({2'b00, sel}, 8'h38);
      drive(6'h11, 5'h11, 2'b01);
      chk({2'b00, sel}, 8'h39);
      drive(6'h11, 5'h11, 2'b11);
      chk({2'b00, sel}, 8'h38);
      drive(6'h11, 5'h01, 2'b00);
      chk({2'b00, sel}, 8'h20);
      drive(6'h20, 5'h00, 2'b00);
      chk({2'b00, sel}, 8'h2A);
      wr(ADDR_ENABLE_TWO, 8'h00);
      drive(6'h20, 5'h00, 2'b00);
      chk({7'h00, sel.valid}, 8'h00);
      wr(ADDR_PRIO_TWO, 8'h01);
      wr(ADDR_ENABLE_TWO, 8'h01);
      drive(6'h21, 5'h01, 2'b00);
      chk({2'b00, sel}, 8'h3A);
      wr(ADDR_PRIO_ONE, 8'h0A);
      drive(6'h10, 5'h10, 2'b00);
      chk({2'b00, sel}, 8'h28);
      drive(6'h08, 5'h08, 2'b00);
      chk({2'b00, sel}, 8'h36);
      drive(6'h02, 5'h02, 2'b00);
      chk({2'b00, sel}, 8'h32);
      drive(6'h06, 5'h06, 2'b00);
      chk({2'b00, sel}, 8'h32);
      wr(ADDR_PRIO_ONE, 8'h00);
      drive(6'h0C, 5'h0C, 2'b00);
      chk({2'b00, sel}, 8'h24);
      wr(ADDR_PRIO_ONE, 8'hFF);
      @(posedge ref_clk_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      #1;
      chk({2'b00, sel}, 8'h00);
      chk({2'b00, prio}, 8'h00);
      rd(ADDR_PRIO_ONE, RST_PRIO_ONE);
      rd(ADDR_ENABLE_TWO, RST_ENABLE_TWO);
      rd(ADDR_PRIO_TWO, RST_PRIO_TWO);
      test_done();
   end
endmodule : interrupt_priority_enable_regs_bench
